// file: rtl/fsr_top.sv
// Frequency speed reference decoder with AXI4-Lite register access
// Overview of operation
// - Four exclusive input formats, codes 0 to 3.
// - Code 1 default: two-track quadrature decoding.
// - Code 2: pulse plus direction, all edges.
// - Code 3: pulse plus direction, rising only.
// - Apply only when enable input or setting.
// - Pulses per rev code 0 off, 64..16384.
// - Scale by numerator over pulses times denominator.
// - Count edges each PWM period, lossless.
// - Time decode edge intervals per 20 ns clock, finer than 25 ns.
// - At least 13-bit resolution at 5 kHz.
// - Method 0 pulses, 1 time, 2 both.
// - Pulses-only method disables linear ramps.
// - Time-only method is linear, ramps allowed.
// - Both: time main, pulses to integral.
// - Both with ramps: ramps on first start only.
// - Position reference always on, offset added.
// - Low-pass filter time value, 0 to 20 ms.
// - Numerator signed, within -16383 to 16383.
`timescale 1ns/1ps
`include "fsr_defs.svh"
module fsr_top #(
  parameter int PWM_DEF_CYC = `FSR_PWM_DEF_CYC
) (
  input  wire logic        CLK_SYS,
  input  wire logic        SYS_RST,
  input  wire logic        TRACK_A,
  input  wire logic        TRACK_B,
  input  wire logic        FREQ_REF_ENABLE_INPUT,
  input  wire logic        RAMP_ENABLE,
  input  wire logic        RUN,
  input  wire logic [31:0] POS_OFFSET,
  input  wire logic        OFFSET_ENABLE,
  input  wire logic [7:0]  S_AXI_AWADDR,
  input  wire logic        S_AXI_AWVALID,
  output logic             S_AXI_AWREADY,
  input  wire logic [31:0] S_AXI_WDATA,
  input  wire logic [3:0]  S_AXI_WSTRB,
  input  wire logic        S_AXI_WVALID,
  output logic             S_AXI_WREADY,
  output logic [1:0]       S_AXI_BRESP,
  output logic             S_AXI_BVALID,
  input  wire logic        S_AXI_BREADY,
  input  wire logic [7:0]  S_AXI_ARADDR,
  input  wire logic        S_AXI_ARVALID,
  output logic             S_AXI_ARREADY,
  output logic [31:0]      S_AXI_RDATA,
  output logic [1:0]       S_AXI_RRESP,
  output logic             S_AXI_RVALID,
  input  wire logic        S_AXI_RREADY,
  output logic [31:0]      MAIN_SPEED_REF,
  output logic [31:0]      INTEGRAL_SPEED_REF,
  output logic             RAMP_ACTIVE,
  output logic             REF_ACTIVE
);

  fsr_pkg::fsr_state_t st_reg;
  fsr_pkg::fsr_state_t st_next;

  // Control and ratio word fields
  logic [1:0]         input_format_select;
  logic [1:0]         ref_method_field;
  logic [3:0]         pulses_per_rev_select;
  logic               freq_ref_enable_setting;
  logic [7:0]         decode_filter_time;
  logic signed [15:0] ratio_numerator;
  logic [15:0]        ratio_denominator;
  logic               freq_ref_enable_flag;
  logic               a_rise;
  logic               a_fall;
  logic               b_rise;
  logic               b_fall;
  logic               edge_hit;
  logic signed [1:0]  step;
  logic               pwm_tick;
  logic signed [63:0] scaled;
  logic [63:0]        divisor;
  logic [4:0]         ppr_log2;
  logic [31:0]        time_val;
  logic [7:0]         filt_shift;
  logic [31:0]        wmask;
  logic [31:0]        wr_val;

  always_comb
  begin
    input_format_select     = st_reg.ctrl[1:0];
    ref_method_field        = st_reg.ctrl[3:2];
    pulses_per_rev_select   = st_reg.ctrl[7:4];
    freq_ref_enable_setting = st_reg.ctrl[8];
    decode_filter_time      = st_reg.ctrl[23:16];
    ratio_numerator         = $signed(st_reg.ratio[15:0]);
    ratio_denominator       = st_reg.ratio[31:16];
  end

  always_comb
  begin
    st_next  = st_reg;
    scaled   = 64'h0;
    divisor  = 64'h1;
    ppr_log2 = 5'h0;
    time_val = 32'h0;
    filt_shift = 8'h0;
    wmask    = 32'h0;
    wr_val   = 32'h0;
    st_next.sa = {st_reg.sa[0], TRACK_A};
    st_next.sb = {st_reg.sb[0], TRACK_B};
    a_rise = st_reg.sa[0] & ~st_reg.sa[1];
    a_fall = ~st_reg.sa[0] & st_reg.sa[1];
    b_rise = st_reg.sb[0] & ~st_reg.sb[1];
    b_fall = ~st_reg.sb[0] & st_reg.sb[1];
    step     = 2'sb00;
    edge_hit = 1'b0;
    unique case (input_format_select)
      `FSR_FMT_QUAD:
      begin
        // Direction from which track leads
        if ((a_rise & ~st_reg.sb[0]) | (a_fall & st_reg.sb[0]) |
            (b_rise & st_reg.sa[0]) | (b_fall & ~st_reg.sa[0]))
          step = 2'sb01;
        else if (a_rise | a_fall | b_rise | b_fall)
          step = -2'sb01;
      end
      `FSR_FMT_FREQ_ALL:
        if (a_rise | a_fall)
          step = st_reg.sb[0] ? -2'sb01 : 2'sb01;
      `FSR_FMT_FREQ_RISE:
        if (a_rise)
          step = st_reg.sb[0] ? -2'sb01 : 2'sb01;
      default: step = 2'sb00;
    endcase
    edge_hit = (step != 2'sb00);
    freq_ref_enable_flag = (FREQ_REF_ENABLE_INPUT | freq_ref_enable_setting)
                           && pulses_per_rev_select != 4'h0
                           && pulses_per_rev_select <= `FSR_PPR_MAX_CODE
                           && ref_method_field <= `FSR_METH_BOTH
                           && input_format_select != `FSR_FMT_ANALOG
                           && ratio_denominator != 16'h0;
    st_next.active = freq_ref_enable_flag;
    // Position always tracks, offset when enabled
    st_next.pos = st_reg.pos + {{30{step[1]}}, step}
                  + (OFFSET_ENABLE ? POS_OFFSET : 32'h0);
    pwm_tick = (st_reg.pwm_cnt + 32'h1 >= st_reg.pwm_per);
    st_next.pwm_cnt = pwm_tick ? 32'h0 : st_reg.pwm_cnt + 32'h1;
    // Interval timer counts every clock, finer than 25 ns
    st_next.ivl_cnt = st_reg.ivl_cnt + 32'h1;
    // Signed edge count so the time value follows direction
    if (edge_hit)
      st_next.ivl_edges = st_reg.ivl_edges + {{14{step[1]}}, step};
    ppr_log2 = 5'(`FSR_PPR_BASE_LOG2) + {1'b0, pulses_per_rev_select};
    divisor  = {48'h0, ratio_denominator} << ppr_log2;
    // Edge count per period with the edge in the tick cycle kept
    if (pwm_tick)
    begin
      st_next.edge_cnt = {{14{step[1]}}, step};
      scaled = 64'($signed(st_reg.edge_cnt)) * 64'(ratio_numerator) * 64'sd60;
      // Rate per period; the edge of the tick cycle carries over
      st_next.pulse_ref = freq_ref_enable_flag ?
                          32'($signed(scaled) / $signed(divisor)) : 32'h0;
      if (st_reg.ivl_edges != 16'h0)
      begin
        st_next.ivl_last  = st_reg.ivl_cnt;
        time_val = 32'((64'($signed(st_reg.ivl_edges)) * 64'(1000000000 / `FSR_CLK_NS) *
                   64'sd60 * 64'(ratio_numerator)) /
                   $signed({32'h0, st_reg.ivl_cnt | 32'h1} * divisor));
        st_next.time_raw  = time_val;
        st_next.ivl_cnt   = 32'h0;
        st_next.ivl_edges = 16'h0;
      end
      // Shift capped so long time constants do not wrap
      filt_shift = ((decode_filter_time >> 3) > 8'h0F) ? 8'h0F : (decode_filter_time >> 3);
      st_next.time_filt = freq_ref_enable_flag ? 32'($signed(st_reg.time_filt) +
                          ($signed(st_next.time_raw - st_reg.time_filt) >>> filt_shift[3:0]))
                          : 32'h0;
    end
    else
      st_next.edge_cnt = st_reg.edge_cnt + {{14{step[1]}}, step};
    unique case (ref_method_field)
      `FSR_METH_PULSE:
      begin
        st_next.main_ref  = st_reg.pulse_ref;
        st_next.integ_ref = 32'h0;
        st_next.ramp_out  = 1'b0;
      end
      `FSR_METH_TIME:
      begin
        st_next.main_ref  = st_reg.time_filt;
        st_next.integ_ref = 32'h0;
        st_next.ramp_out  = RAMP_ENABLE;
      end
      `FSR_METH_BOTH:
      begin
        st_next.main_ref  = st_reg.time_filt;
        st_next.integ_ref = st_reg.pulse_ref;
        st_next.ramp_out  = RAMP_ENABLE & ~st_reg.started;
        if (RUN)
          st_next.started = 1'b1;
      end
      default:
      begin
        st_next.main_ref  = 32'h0;
        st_next.integ_ref = 32'h0;
        st_next.ramp_out  = 1'b0;
      end
    endcase
    if (!freq_ref_enable_flag)
    begin
      st_next.main_ref  = 32'h0;
      st_next.integ_ref = 32'h0;
      st_next.ramp_out  = 1'b0;
    end
    // AXI write channel
    if (S_AXI_AWVALID & st_reg.awready)
    begin
      st_next.have_aw = 1'b1;
      st_next.awaddr  = S_AXI_AWADDR;
    end
    if (S_AXI_WVALID & st_reg.wready)
    begin
      st_next.have_w = 1'b1;
      st_next.wdata  = S_AXI_WDATA;
    end
    if (st_reg.have_aw & st_reg.have_w)
    begin
      for (int i = 0; i < 4; i++)
        wmask[i*8 +: 8] = {8{S_AXI_WSTRB[i]}};
      wr_val = st_reg.wdata;
      unique case (st_reg.awaddr)
        `FSR_A_CTRL:
        begin
          if (wr_val[23:16] > `FSR_FILT_MAX_X10)
            wr_val[23:16] = `FSR_FILT_MAX_X10;
          st_next.ctrl = (st_reg.ctrl & ~wmask) | (wr_val & wmask);
        end
        `FSR_A_RATIO:
        begin
          // Numerator clamped to its signed range
          if ($signed(wr_val[15:0]) > 16'sd16383)
            wr_val[15:0] = 16'h3FFF;
          else if ($signed(wr_val[15:0]) < -16'sd16383)
            wr_val[15:0] = 16'hC001;
          st_next.ratio = (st_reg.ratio & ~wmask) | (wr_val & wmask);
        end
        `FSR_A_PWM:
          st_next.pwm_per = (st_reg.pwm_per & ~wmask) | (wr_val & wmask);
        default: st_next.ctrl = st_reg.ctrl;
      endcase
      st_next.have_aw = 1'b0;
      st_next.have_w  = 1'b0;
      st_next.bvalid  = 1'b1;
    end
    if (st_reg.bvalid & S_AXI_BREADY)
      st_next.bvalid = 1'b0;
    // Readies stay low while a response is pending
    st_next.awready = ~st_next.have_aw & ~st_next.bvalid;
    st_next.wready  = ~st_next.have_w & ~st_next.bvalid;
    // AXI read channel
    st_next.arready = ~st_reg.rvalid & ~(S_AXI_ARVALID & st_reg.arready);
    if (S_AXI_ARVALID & st_reg.arready)
    begin
      st_next.rvalid = 1'b1;
      st_next.rresp  = 2'h0;
      unique case (S_AXI_ARADDR)
        `FSR_A_CTRL:      st_next.rdata = st_reg.ctrl;
        `FSR_A_RATIO:     st_next.rdata = st_reg.ratio;
        `FSR_A_PWM:       st_next.rdata = st_reg.pwm_per;
        `FSR_A_PULSE_REF: st_next.rdata = st_reg.pulse_ref;
        `FSR_A_TIME_REF:  st_next.rdata = st_reg.time_filt;
        `FSR_A_STATUS:    st_next.rdata = {29'h0, st_reg.started, st_reg.ramp_out,
                                           st_reg.active};
        `FSR_A_POS:       st_next.rdata = st_reg.pos;
        default:
        begin
          st_next.rdata = 32'h0;
          st_next.rresp = 2'h2;
        end
      endcase
    end
    else if (st_reg.rvalid & S_AXI_RREADY)
      st_next.rvalid = 1'b0;
  end

  always_ff @(posedge CLK_SYS or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      st_reg         <= '0;
      st_reg.ctrl    <= `FSR_CTRL_RST | (32'(`FSR_FILT_DEF_X10) << 16);
      st_reg.ratio   <= `FSR_RATIO_RST;
      st_reg.pwm_per <= 32'(PWM_DEF_CYC);
    end
    else
      st_reg <= st_next;
  end

  assign S_AXI_AWREADY      = st_reg.awready;
  assign S_AXI_WREADY       = st_reg.wready;
  assign S_AXI_BVALID       = st_reg.bvalid;
  assign S_AXI_BRESP        = 2'h0;
  assign S_AXI_ARREADY      = st_reg.arready;
  assign S_AXI_RVALID       = st_reg.rvalid;
  assign S_AXI_RDATA        = st_reg.rdata;
  assign S_AXI_RRESP        = st_reg.rresp;
  assign MAIN_SPEED_REF     = st_reg.main_ref;
  assign INTEGRAL_SPEED_REF = st_reg.integ_ref;
  assign RAMP_ACTIVE        = st_reg.ramp_out;
  assign REF_ACTIVE         = st_reg.active;

endmodule : fsr_top

// file: rtl/fsr_defs.svh
// Constants for the frequency speed reference decoder
`ifndef FSR_DEFS_SVH
`define FSR_DEFS_SVH
`define FSR_FMT_ANALOG      2'h0
`define FSR_FMT_QUAD        2'h1
`define FSR_FMT_FREQ_ALL    2'h2
`define FSR_FMT_FREQ_RISE   2'h3
`define FSR_METH_PULSE      2'h0
`define FSR_METH_TIME       2'h1
`define FSR_METH_BOTH       2'h2
`define FSR_PPR_MAX_CODE    4'h9
`define FSR_PPR_BASE_LOG2   5
`define FSR_TICK_NS         25
`define FSR_CLK_NS          20
`define FSR_TICK_CYC        ((`FSR_TICK_NS + `FSR_CLK_NS - 1) / `FSR_CLK_NS)
`define FSR_MAX_FREQ_KHZ    300
`define FSR_NUM_MAX         16383
`define FSR_FILT_DEF_X10    8'h10
`define FSR_FILT_MAX_X10    8'hC8
`define FSR_PWM_DEF_CYC     10000
`define FSR_A_CTRL          8'h00
`define FSR_A_RATIO         8'h04
`define FSR_A_PWM           8'h08
`define FSR_A_PULSE_REF     8'h0C
`define FSR_A_TIME_REF      8'h10
`define FSR_A_STATUS        8'h14
`define FSR_A_POS           8'h18
`define FSR_CTRL_RST        32'h0000_0051
`define FSR_RATIO_RST       32'h0064_0064
`endif

// file: rtl/fsr_pkg.sv
// Types for the frequency speed reference decoder
package fsr_pkg;
  typedef enum logic [1:0] {AX_IDLE, AX_BRESP} fsr_wst_t;
  typedef struct packed {
    logic [1:0]  sa;
    logic [1:0]  sb;
    logic [15:0] edge_cnt;
    logic [31:0] pwm_cnt;
    logic [31:0] ivl_cnt;
    logic [31:0] ivl_last;
    logic [15:0] ivl_edges;
    logic [31:0] pos;
    logic [31:0] pulse_ref;
    logic [31:0] time_raw;
    logic [31:0] time_filt;
    logic        started;
    logic        ramp_out;
    logic [31:0] ctrl;
    logic [31:0] ratio;
    logic [31:0] pwm_per;
    logic        have_aw;
    logic        have_w;
    logic [7:0]  awaddr;
    logic [31:0] wdata;
    logic        bvalid;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic        arready;
    logic        awready;
    logic        wready;
    logic [31:0] main_ref;
    logic [31:0] integ_ref;
    logic        active;
  } fsr_state_t;
endpackage : fsr_pkg

// file: tb/fsr_assertions.sv
// Port checker for the frequency speed reference decoder
`timescale 1ns/1ps
module fsr_assertions (
  input wire logic        CLK_SYS,
  input wire logic        SYS_RST,
  input wire logic        S_AXI_AWVALID,
  input wire logic        S_AXI_AWREADY,
  input wire logic        S_AXI_WVALID,
  input wire logic        S_AXI_WREADY,
  input wire logic [1:0]  S_AXI_BRESP,
  input wire logic        S_AXI_BVALID,
  input wire logic        S_AXI_BREADY,
  input wire logic        S_AXI_ARVALID,
  input wire logic        S_AXI_ARREADY,
  input wire logic [31:0] S_AXI_RDATA,
  input wire logic        S_AXI_RVALID,
  input wire logic        S_AXI_RREADY,
  input wire logic        RAMP_ENABLE,
  input wire logic        RAMP_ACTIVE
);
  default clocking cb @(posedge CLK_SYS);
  endclocking
  default disable iff (SYS_RST);
  sequence wr_taken;
    S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY;
  endsequence
  sequence wr_answered;
    ##[1:3] S_AXI_BVALID;
  endsequence
  AST_WR_ANSWER: assert property (wr_taken |-> wr_answered)
    else $error("write response late");
  AST_B_OKAY: assert property (S_AXI_BVALID |-> S_AXI_BRESP == 2'h0)
    else $error("write response not okay");
  AST_B_HOLD: assert property (S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID)
    else $error("write response dropped");
  AST_R_HOLD: assert property (S_AXI_RVALID && !S_AXI_RREADY |=>
    S_AXI_RVALID && $stable(S_AXI_RDATA)) else $error("read data not held");
  AST_RD_ANSWER: assert property (S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID)
    else $error("read answer late");
  AST_AR_BLOCK: assert property (S_AXI_RVALID |-> !S_AXI_ARREADY)
    else $error("read taken while answer pending");
  AST_W_BLOCK: assert property (S_AXI_BVALID |-> !S_AXI_AWREADY && !S_AXI_WREADY)
    else $error("write taken while answer pending");
  AST_RAMP_OFF: assert property (!RAMP_ENABLE [*3] |-> !RAMP_ACTIVE)
    else $error("ramp active without request");
endmodule : fsr_assertions
bind fsr_top fsr_assertions i_fsr_assertions (.*);

// file: tb/fsr_enc_model.sv
// Encoder or pulse-plus-direction source feeding the decoder
`timescale 1ns/1ps
module fsr_enc_model #(
  parameter int STEP = 84
) (
  input  wire logic clk,
  input  wire logic move,
  input  wire logic quad,
  input  wire logic down,
  output logic      trk_a,
  output logic      trk_b
);
  int         cnt = 0;
  logic [1:0] ph  = 2'h0;
  // Tracks stand still while not moving
  always @(posedge clk)
  begin
    if (move)
      cnt <= (cnt == STEP - 1) ? 0 : cnt + 1;
    if (move && cnt == STEP - 1)
      ph <= down ? ph - 2'h1 : ph + 2'h1;
  end
  assign trk_a = quad ? ph[1] : ph[0];
  assign trk_b = quad ? ph[1] ^ ph[0] : down;
endmodule : fsr_enc_model

// file: tb/testbench.sv
// Self-checking bench for the frequency speed reference decoder
`timescale 1ns/1ps
module testbench;
  typedef struct packed {
    logic [31:0] c;
    logic        e;
    logic        x;
  } fsr_row_t;
  localparam fsr_row_t ROWS [13] = '{
    '{32'h151, 1'h0, 1'h1}, '{32'h051, 1'h1, 1'h1}, '{32'h051, 1'h0, 1'h0},
    '{32'h050, 1'h1, 1'h0}, '{32'h052, 1'h1, 1'h1}, '{32'h053, 1'h1, 1'h1},
    '{32'h055, 1'h1, 1'h1}, '{32'h059, 1'h1, 1'h1}, '{32'h05D, 1'h1, 1'h0},
    '{32'h001, 1'h1, 1'h0}, '{32'h011, 1'h1, 1'h1}, '{32'h091, 1'h1, 1'h1},
    '{32'h0A1, 1'h1, 1'h0}};
  logic        CLK_SYS = 1'h0;
  logic        SYS_RST = 1'h1;
  logic        TRACK_A, TRACK_B, FREQ_REF_ENABLE_INPUT, RAMP_ENABLE, RUN, OFFSET_ENABLE;
  logic        S_AXI_AWVALID, S_AXI_AWREADY, S_AXI_WVALID, S_AXI_WREADY, S_AXI_BVALID;
  logic        S_AXI_BREADY, S_AXI_ARVALID, S_AXI_ARREADY, S_AXI_RVALID, S_AXI_RREADY;
  logic        RAMP_ACTIVE, REF_ACTIVE, mv, qd, dn;
  logic [1:0]  S_AXI_BRESP, S_AXI_RRESP, r;
  logic [3:0]  S_AXI_WSTRB;
  logic [7:0]  S_AXI_AWADDR, S_AXI_ARADDR;
  logic [31:0] POS_OFFSET, S_AXI_WDATA, S_AXI_RDATA, MAIN_SPEED_REF, INTEGRAL_SPEED_REF;
  logic [31:0] d, p1, p2;
  int          n_fail = 0;
  int          comparisons = 0;
  always #10 CLK_SYS = ~CLK_SYS;
  fsr_top #(.PWM_DEF_CYC(400)) i_fsr_top (.*);
  fsr_enc_model i_fsr_enc_model (.clk(CLK_SYS), .move(mv), .quad(qd), .down(dn),
                                 .trk_a(TRACK_A), .trk_b(TRACK_B));
  task automatic final_report;
    $display("comparisons %0d, mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : final_report
  task automatic fail(input string m);
    n_fail++;
    $display("wrong value at %0t ns: %s", $time, m);
  endtask : fail
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e)
      fail($sformatf("got %h want %h", g, e));
  endtask : chk
  task automatic cond(input logic c);
    comparisons++;
    if (c !== 1'h1)
      fail("relation does not hold");
  endtask : cond
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    int n;
    S_AXI_AWADDR  <= a;
    S_AXI_WDATA   <= v;
    S_AXI_AWVALID <= 1'h1;
    S_AXI_WVALID  <= 1'h1;
    S_AXI_BREADY  <= 1'h1;
    for (n = 0; n < 50; n++)
    begin
      @(posedge CLK_SYS);
      if (S_AXI_AWREADY)
        S_AXI_AWVALID <= 1'h0;
      if (S_AXI_WREADY)
        S_AXI_WVALID <= 1'h0;
      if (S_AXI_BVALID)
        break;
    end
    S_AXI_BREADY <= 1'h0;
    if (n == 50)
      fail("write hung");
    if (n == 50)
      final_report();
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    int n;
    S_AXI_ARADDR  <= a;
    S_AXI_ARVALID <= 1'h1;
    S_AXI_RREADY  <= 1'h1;
    for (n = 0; n < 50; n++)
    begin
      @(posedge CLK_SYS);
      if (S_AXI_ARREADY)
        S_AXI_ARVALID <= 1'h0;
      if (S_AXI_RVALID)
        break;
    end
    v = S_AXI_RDATA;
    r = S_AXI_RRESP;
    S_AXI_RREADY <= 1'h0;
    if (n == 50)
      fail("read hung");
    if (n == 50)
      final_report();
  endtask : rd
  initial
  begin
    {FREQ_REF_ENABLE_INPUT, RAMP_ENABLE, RUN, OFFSET_ENABLE, POS_OFFSET} = '0;
    {S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY, S_AXI_ARVALID, S_AXI_RREADY} = '0;
    {S_AXI_AWADDR, S_AXI_ARADDR, S_AXI_WDATA, mv, qd, dn} = '0;
    S_AXI_WSTRB = 4'hF;
    repeat (6) @(posedge CLK_SYS);
    SYS_RST <= 1'h0;
    repeat (2) @(posedge CLK_SYS);
    rd(8'h00, d);
    chk(d, 32'h0010_0051);
    rd(8'h40, d);
    chk({d[29:0], r}, 32'h0000_0002);
    wr(8'h04, 32'h0064_7FFF);
    rd(8'h04, d);
    chk(d, 32'h0064_3FFF);
    wr(8'h04, 32'h0064_8000);
    rd(8'h04, d);
    chk(d, 32'h0064_C001);
    wr(8'h04, 32'h0000_0064);
    wr(8'h00, 32'h0000_0151);
    wr(8'h40, 32'hFFFF_FFFF);
    rd(8'h00, d);
    chk(d, 32'h0000_0151);
    chk(32'(REF_ACTIVE), 32'h0);
    wr(8'h04, 32'h0064_0064);
    $display("done: registers");
    foreach (ROWS[i])
    begin
      FREQ_REF_ENABLE_INPUT <= ROWS[i].e;
      wr(8'h00, ROWS[i].c);
      repeat (3) @(posedge CLK_SYS);
      chk(32'(REF_ACTIVE), 32'(ROWS[i].x));
    end
    FREQ_REF_ENABLE_INPUT <= 1'h0;
    $display("done: selector table");
    wr(8'h00, 32'h0000_0119);
    mv <= 1'h1;
    qd <= 1'h1;
    repeat (4000) @(posedge CLK_SYS);
    rd(8'h0C, p1);
    cond(INTEGRAL_SPEED_REF !== 32'h0 && MAIN_SPEED_REF !== 32'h0 &&
         MAIN_SPEED_REF[31] === INTEGRAL_SPEED_REF[31]);
    rd(8'h10, d);
    cond(d !== 32'h0 && d[31] === p1[31]);
    dn <= 1'h1;
    repeat (8000) @(posedge CLK_SYS);
    rd(8'h0C, p2);
    cond(p1 !== 32'h0 && p2 !== 32'h0 && p1[31] !== p2[31]);
    wr(8'h00, 32'h0000_0111);
    RAMP_ENABLE <= 1'h1;
    repeat (2000) @(posedge CLK_SYS);
    chk(INTEGRAL_SPEED_REF, 32'h0);
    chk(32'(RAMP_ACTIVE), 32'h0);
    {dn, qd} <= 2'h0;
    wr(8'h00, 32'h0000_0112);
    repeat (2000) @(posedge CLK_SYS);
    rd(8'h0C, p1);
    wr(8'h00, 32'h0000_0113);
    repeat (2000) @(posedge CLK_SYS);
    rd(8'h0C, p2);
    cond($signed(p1) > $signed(p2) && $signed(p2) > 0);
    cond($signed(p1) >= 3 && $signed(p1) <= 4);
    $display("done: pulse counting");
    wr(8'h00, 32'h0000_0119);
    repeat (5) @(posedge CLK_SYS);
    chk(32'(RAMP_ACTIVE), 32'h1);
    RUN <= 1'h1;
    repeat (5) @(posedge CLK_SYS);
    RUN <= 1'h0;
    repeat (5) @(posedge CLK_SYS);
    chk(32'(RAMP_ACTIVE), 32'h0);
    $display("done: ramps");
    qd <= 1'h1;
    wr(8'h00, 32'h0000_0011);
    rd(8'h18, p1);
    repeat (1000) @(posedge CLK_SYS);
    rd(8'h18, p2);
    cond(p1 !== p2 && REF_ACTIVE === 1'h0);
    mv <= 1'h0;
    repeat (5) @(posedge CLK_SYS);
    rd(8'h18, p1);
    OFFSET_ENABLE <= 1'h1;
    POS_OFFSET    <= 32'h0000_0010;
    repeat (10) @(posedge CLK_SYS);
    OFFSET_ENABLE <= 1'h0;
    rd(8'h18, p2);
    chk(p2 - p1, 32'h0000_00A0);
    $display("done: position");
    wr(8'h00, 32'h0000_0115);
    repeat (5) @(posedge CLK_SYS);
    chk(32'({RAMP_ACTIVE, REF_ACTIVE}), 32'h0000_0003);
    chk(INTEGRAL_SPEED_REF, 32'h0);
    SYS_RST <= 1'h1;
    repeat (2) @(posedge CLK_SYS);
    chk(32'({RAMP_ACTIVE, REF_ACTIVE, S_AXI_BVALID, S_AXI_RVALID}), 32'h0);
    chk(32'({S_AXI_AWREADY, S_AXI_WREADY, S_AXI_ARREADY}), 32'h0);
    chk(MAIN_SPEED_REF, 32'h0);
    SYS_RST <= 1'h0;
    repeat (2) @(posedge CLK_SYS);
    rd(8'h08, d);
    chk(d, 32'h0000_0190);
    rd(8'h00, d);
    chk(d, 32'h0010_0051);
    $display("done: reset");
    final_report();
  end
endmodule : testbench
